// ---- hdl/keypad_spi_defines.svh ----
`ifndef KEYPAD_SPI_DEFINES_SVH
`define KEYPAD_SPI_DEFINES_SVH
// ***********************************
// packet layout
// ***********************************
`define PKT_BITS 8
`define PKT_CNT_W 3
`define ROW_LSB 0
`define ROW_MSB 3
`define LED_LSB 4
`define LED_MSB 5
`define ROW_COUNT 4
`define COL_COUNT 8
`define ROW_RESET 4'h0
`define LED_RESET 2'h0
`define COL_IDLE 8'hff
// ***********************************
// host timing
// ***********************************
`define SCLK_DIV 5
`define SCLK_DIV_W 3
// ***********************************
// host wishbone map
// ***********************************
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_COLS 32'h0000_0008
`define CTRL_START_BIT 8
`define STATUS_BUSY_BIT 0
`define STATUS_DONE_BIT 1
`endif

// ---- hdl/keypad_spi_pkg.sv ----
`include "keypad_spi_defines.svh"
package keypad_spi_pkg;
   typedef logic [`PKT_BITS-1:0] pkt_t;
   typedef logic [`ROW_MSB:0] row_t;
   typedef logic [1:0] led_t;
   typedef logic [`COL_COUNT-1:0] col_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_SHIFT = 3'b010,
      H_DONE = 3'b100
   } host_state_t;
endpackage

// ---- hdl/keypad_spi_if.sv ----
`timescale 1ns/1ps
interface keypad_spi_if;
   logic sclk;
   logic selN;
   logic mosi;
   logic miso;
   modport scanner (input sclk, input selN, input mosi, output miso);
   modport master (output sclk, output selN, output mosi, input miso);
endinterface

// ---- hdl/keypad_scanner.sv ----
`timescale 1ns/1ps
`include "keypad_spi_defines.svh"
// Contract
// - scanner is slave only, master drives clock
// - full duplex on one shared serial clock
// - latch rows and leds at packet end
// - board reset clears latched rows and leds
// - latched row bits drive row outputs directly
// - capture columns on edge, hold for return
// - captured columns shifted out on data line
// - four rows, eight columns, walking zero
// - master sends exactly one low row
// - master walks low row through all rows
// - eight-bit shift register plus holding latch
// - next packet shifts out previous columns
// - pressed key returns zero, idle one
// - master pairs previous row with zero column
// - bits four and five drive the leds
// - bits zero to three rows, six seven ignored
// - master makes flashing, scanner has no timer
module keypad_scanner
   import keypad_spi_pkg::*;
(
   keypad_spi_if.scanner spi,
   input wire logic board_reset_n,
   input wire keypad_spi_pkg::col_t keypad_column_lines,
   output keypad_spi_pkg::row_t keypad_row_lines,
   output keypad_spi_pkg::led_t led_drive_bits
);
   import keypad_spi_pkg::*;
   // ***********************************
   // state, all on the serial clock
   // ***********************************
   // the master's clock only runs during packets, so all work
   // completes on the eighth edge; rows hold between packets
   typedef struct packed {
      logic [1:0] rstSync;
      pkt_t rxShift;
      pkt_t txShift;
      logic [`PKT_CNT_W-1:0] bitCnt;
      col_t colSync1;
      col_t colSync2;
      row_t rows;
      led_t leds;
   } scan_state_t;
   scan_state_t s, next_s;
   logic misoOut;
   assign keypad_row_lines = s.rows;
   assign led_drive_bits = s.leds;
   assign spi.miso = misoOut;
   always_comb begin
      next_s = s;
      next_s.rstSync = {s.rstSync[0], 1'b1};
      next_s.colSync1 = keypad_column_lines;
      next_s.colSync2 = s.colSync1;
      if (!spi.selN) begin
         next_s.rxShift = {s.rxShift[`PKT_BITS-2:0], spi.mosi};
         next_s.txShift = {s.txShift[`PKT_BITS-2:0], 1'b1};
         next_s.bitCnt = s.bitCnt + 1'b1;
         if (s.bitCnt == `PKT_CNT_W'(`PKT_BITS - 1)) begin
            next_s.rows = {s.rxShift[`ROW_MSB-1:0], spi.mosi};
            next_s.leds = s.rxShift[`LED_MSB-1:`LED_LSB-1];
            // columns under the pattern just ending, zero = pressed
            next_s.txShift = s.colSync2;
         end
      end else begin
         next_s.bitCnt = '0;
      end
      if (!s.rstSync[1]) begin
         next_s.rows = `ROW_RESET;
         next_s.leds = `LED_RESET;
         next_s.txShift = `COL_IDLE;
         // bit count keeps running: no clock between frames to realign it,
         // so only board reset does; every frame must bring eight edges
      end
   end
   // row count and column count fixed by the types
   always_ff @(posedge spi.sclk or negedge board_reset_n) begin
      if (!board_reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   // miso changes on the falling edge, half a bit ahead of sampling
   always_ff @(negedge spi.sclk or negedge board_reset_n) begin
      if (!board_reset_n) begin
         misoOut <= 1'b1;
      end else begin
         misoOut <= s.txShift[`PKT_BITS-1];
      end
   end
endmodule

// ---- hdl/keypad_host.sv ----
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "keypad_spi_defines.svh"
module keypad_host
   import keypad_spi_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   keypad_spi_if.master spi,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import keypad_spi_pkg::*;
   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      host_state_t st;
      pkt_t txByte;
      pkt_t shift;
      col_t cols;
      logic [`PKT_CNT_W:0] bitCnt;
      logic [`SCLK_DIV_W-1:0] div;
      logic sclk;
      logic selN;
      logic mosi;
      logic done;
      logic misoS1;
      logic misoS2;
      logic ack;
      logic [31:0] dat;
   } host_reg_t;
   host_reg_t r, next_r;
   assign spi.sclk = r.sclk;
   assign spi.selN = r.selN;
   assign spi.mosi = r.mosi;
   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.dat;
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      next_r.misoS1 = spi.miso;
      next_r.misoS2 = r.misoS1;
      if (wb_cyc_i && wb_stb_i && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.dat = 32'h0000_0000;
         if (wb_adr_i == `REG_CTRL) begin
            next_r.dat = {24'h00_0000, r.txByte};
            if (wb_we_i && wb_sel_i[0] && r.st == H_IDLE) begin
               next_r.txByte = wb_dat_i[`PKT_BITS-1:0];
               if (wb_sel_i[1] && wb_dat_i[`CTRL_START_BIT]) begin
                  next_r.st = H_SHIFT;
                  next_r.selN = 1'b0;
                  next_r.done = 1'b0;
                  next_r.shift = wb_dat_i[`PKT_BITS-1:0];
                  next_r.mosi = wb_dat_i[`PKT_BITS-1];
                  next_r.bitCnt = '0;
                  next_r.div = '0;
               end
            end
         end else if (wb_adr_i == `REG_STATUS) begin
            next_r.dat[`STATUS_BUSY_BIT] = r.st != H_IDLE;
            next_r.dat[`STATUS_DONE_BIT] = r.done;
         end else if (wb_adr_i == `REG_COLS) begin
            next_r.dat = {24'h00_0000, r.cols};
         end
      end
      case (r.st)
         H_IDLE: begin
         end
         H_SHIFT: begin
            next_r.div = r.div + 1'b1;
            if (r.div == `SCLK_DIV_W'(`SCLK_DIV - 1)) begin
               next_r.div = '0;
               next_r.sclk = !r.sclk;
               if (r.sclk) begin
                  // falling edge: next bit out
                  next_r.shift = {r.shift[`PKT_BITS-2:0], r.misoS2};
                  next_r.mosi = r.shift[`PKT_BITS-2];
                  next_r.bitCnt = r.bitCnt + 1'b1;
                  if (r.bitCnt == (`PKT_CNT_W+1)'(`PKT_BITS - 1)) begin
                     next_r.st = H_DONE;
                  end
               end
            end
         end
         H_DONE: begin
            next_r.selN = 1'b1;
            next_r.cols = r.shift;
            next_r.done = 1'b1;
            next_r.st = H_IDLE;
         end
         default: begin
            next_r.st = H_IDLE;
         end
      endcase
      if (srst) begin
         next_r = '0;
         next_r.st = H_IDLE;
         next_r.selN = 1'b1;
         next_r.txByte = 8'hff;
         next_r.cols = `COL_IDLE;
      end
   end
   always_ff @(posedge clk) begin
      r <= next_r;
   end
endmodule

// ---- testbench/keypad_spi_monitor.sv ----
`timescale 1ns/1ps
module keypad_spi_monitor (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic selN,
   input wire logic mosi,
   input wire logic miso
);
   // ***********************************
   // wire checks
   // ***********************************
   logic [3:0] edges;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   always_ff @(posedge clk) begin
      if (srst || $fell(selN)) begin
         edges <= 4'h0;
      end else if ($rose(sclk)) begin
         edges <= edges + 4'h1;
      end
   end
   sequence highHalf;
      sclk [*5] ##1 !sclk;
   endsequence
   sequence mosiSteady;
      $stable(mosi) [*4];
   endsequence
   a_clock_idle_out: assert property (selN |-> !sclk)
      else $error("serial clock moves outside a frame");
   a_clock_half_high: assert property ($rose(sclk) |-> highHalf)
      else $error("serial clock high half has wrong length");
   a_frame_starts_low: assert property ($fell(selN) |-> !sclk [*2])
      else $error("frame opens with clock high");
   a_mosi_held_high: assert property ($rose(sclk) |-> mosiSteady)
      else $error("master data moves while clock high");
   a_miso_held_high: assert property ($rose(sclk) |-> $stable(miso) [*4])
      else $error("scanner data moves while clock high");
   a_frame_eight_edges: assert property ($rose(selN) |-> edges == 4'h8)
      else $error("frame without eight clock edges");
   a_select_held: assert property ($fell(selN) |-> !selN [*8])
      else $error("select pulse too short");
   a_miso_ready_early: assert property ($fell(selN) |-> $stable(miso))
      else $error("scanner first bit not ready at frame start");
endmodule

// ---- testbench/spi_keypad_scanner_slave_tb.sv ----
`timescale 1ns/1ps
`include "keypad_spi_defines.svh"
module spi_keypad_scanner_slave_tb;
   import keypad_spi_pkg::*;
   // ***********************************
   // bench
   // ***********************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic boardResetN = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] datI = 32'h0;
   logic [31:0] datO;
   logic [31:0] rd;
   logic ack;
   col_t cols = 8'hff;
   row_t rows;
   led_t leds;
   logic [7:0] wireOut;
   logic [7:0] wireIn;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   keypad_spi_if spi ();
   keypad_scanner i_keypad_scanner (.spi(spi.scanner), .board_reset_n(boardResetN),
      .keypad_column_lines(cols), .keypad_row_lines(rows), .led_drive_bits(leds));
   keypad_host i_keypad_host (.clk(clk), .srst(srst), .spi(spi.master), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(datI),
      .wb_dat_o(datO), .wb_ack_o(ack));
   keypad_spi_monitor i_keypad_spi_monitor (.clk(clk), .srst(srst), .sclk(spi.sclk),
      .selN(spi.selN), .mosi(spi.mosi), .miso(spi.miso));
   always #12.5 clk = ~clk;
   // wire seen independently of both ends
   always @(posedge spi.sclk) begin
      if (!spi.selN) begin
         wireOut <= {wireOut[6:0], spi.mosi};
         wireIn <= {wireIn[6:0], spi.miso};
      end
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         stop_test;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic send(input logic [7:0] b);
      wb(1'b1, `REG_CTRL, (32'h1 << `CTRL_START_BIT) | {24'h0, b});
      // a second start while busy must be refused
      wb(1'b1, `REG_CTRL, (32'h1 << `CTRL_START_BIT) | {24'h0, ~b});
      do wb(1'b0, `REG_STATUS, 32'h0);
      while (rd[`STATUS_BUSY_BIT] !== 1'b0 || rd[`STATUS_DONE_BIT] !== 1'b1);
      chk({24'h0, wireOut}, {24'h0, b});
      wb(1'b0, `REG_CTRL, 32'h0);
      chk(rd, {24'h0, b});
   endtask
   // leds and ignored bits vary with each walking-zero row
   task automatic scan_rows;
      logic [7:0] b;
      col_t prev;
      for (int i = 0; i < 4; i++) begin
         b = {2'(i), 2'(i + 1), 4'hf ^ (4'h1 << i)};
         // columns standing during one frame come back in the next
         prev = cols;
         cols <= ~(8'h1 << (2 * i + 1));
         send(b);
         chk({28'h0, rows}, {28'h0, b[3:0]});
         chk({30'h0, leds}, {30'h0, b[5:4]});
         chk({24'h0, wireIn}, {24'h0, prev});
         wb(1'b0, `REG_COLS, 32'h0);
         chk(rd, {24'h0, prev});
      end
   endtask
   // first frame after release returns idle columns and still latches
   task automatic board_reset;
      boardResetN <= 1'b0;
      repeat (3) @(posedge clk);
      chk({28'h0, rows}, 32'h0);
      chk({30'h0, leds}, 32'h0);
      boardResetN <= 1'b1;
      send(8'hff);
      chk({24'h0, wireIn}, {24'h0, `COL_IDLE});
      chk({28'h0, rows}, 32'h0000_000f);
      chk({30'h0, leds}, 32'h0000_0003);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      board_reset;
      scan_rows;
      wb(1'b0, 32'h0000_0010, 32'h0);
      chk(rd, 32'h0);
      board_reset;
      scan_rows;
      stop_test;
   end
endmodule
